// File: dpbr_top.sv
// Summary of operation
// - Two independent ports share only stored contents
// - All accesses happen only on clock edges
// - Address and output data held between accesses
// - Optional output register adds one cycle latency
// - Write mode: old, new or unchanged output
// - Port shapes 32Kx1 up to 512x72
// - Ports map differing widths onto same storage
// - Split into two halves, up to 512x36
// - Widest shapes only in wide read/write mode with split off
// - Wide mode: write side fixed at full width
// - Two blocks cascade into 64Kx1 memory; upper block forwards low reads only until its first access
// - Eight check bits, correct single, flag double
// - Encoder and decoder usable standalone
// - Queue advances its own pointers
// - Queue reports full, empty, almost flags
// - Almost thresholds are programmable
// - Queue write and read widths identical
// - Look-ahead shows first word before read
//
// The register addresses and the strobed register port are this design's own decisions.
module dpbr_top
  import dpbr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [REG_AW-1:0] regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [31:0]       regRdata,
  output logic                   irq,
  input  wire logic              enA,
  input  wire logic              weA,
  input  wire logic              halfA,
  input  wire logic [ADDR_W-1:0] addrA,
  input  wire logic [ROW_W-1:0]  dinA,
  output logic      [ROW_W-1:0]  doutA,
  input  wire logic              enB,
  input  wire logic              weB,
  input  wire logic              halfB,
  input  wire logic [ADDR_W-1:0] addrB,
  input  wire logic [ROW_W-1:0]  dinB,
  output logic      [ROW_W-1:0]  doutB,
  input  wire logic              cascInA,
  input  wire logic              cascInB,
  output logic                   cascOutA,
  output logic                   cascOutB,
  input  wire logic              fifoWr,
  input  wire logic [ROW_W-1:0]  fifoDin,
  input  wire logic              fifoRd,
  output logic      [ROW_W-1:0]  fifoDout,
  output logic                   fifoFull,
  output logic                   fifoEmpty,
  output logic                   fifoAlmostFull,
  output logic                   fifoAlmostEmpty,
  output logic                   eccSingle,
  output logic                   eccDouble,
  input  wire logic [63:0]       extEncIn,
  output logic      [7:0]        extEncCheck,
  input  wire logic [ROW_W-1:0]  extDecIn,
  output logic      [63:0]       extDecOut,
  output logic                   extDecSingle,
  output logic                   extDecDouble
);
  localparam int NP = 2;

  function automatic logic [6:0] wBits(input logic [2:0] c);
    case (c)
      W1:      wBits = 7'd1;
      W2:      wBits = 7'd2;
      W4:      wBits = 7'd4;
      W9:      wBits = 7'd9;
      W18:     wBits = 7'd18;
      W36:     wBits = 7'd36;
      default: wBits = 7'd72;
    endcase
  endfunction

  function automatic logic [8:0] rowOf(input logic [2:0] c, input logic [15:0] a);
    rowOf = 9'(a >> (3'd6 - c));
  endfunction

  // Narrow shapes use data bits only; each 9-bit lane keeps its parity bit on top
  function automatic logic [6:0] bitOfs(input logic [2:0] c, input logic [15:0] a);
    case (c)
      W1:      bitOfs = 7'(9 * a[5:3] + a[2:0]);
      W2:      bitOfs = 7'(9 * a[4:2] + 2 * a[1:0]);
      W4:      bitOfs = 7'(9 * a[3:1] + 4 * a[0]);
      W9:      bitOfs = 7'(9 * a[2:0]);
      W18:     bitOfs = 7'(18 * a[1:0]);
      W36:     bitOfs = 7'(36 * a[0]);
      default: bitOfs = 7'd0;
    endcase
  endfunction

  function automatic logic [2:0] clampW(input logic [2:0] r, input logic [2:0] cap,
                                        input logic casc);
    if (casc)
      clampW = W1;
    else
      clampW = (r > cap) ? cap : r;
  endfunction

  // Hamming positions 1..71, check bits at powers of two, c[7] is overall parity
  function automatic logic [7:0] eccChk(input logic [63:0] d);
    logic [7:0] c;
    int k;
    c = 8'h00;
    k = 0;
    for (int p = 3; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int j = 0; j < 7; j++) begin
          if (p[j])
            c[j] = c[j] ^ d[k];
        end
        k++;
      end
    end
    c[7] = ^{d, c[6:0]};
    return c;
  endfunction

  function automatic logic [65:0] eccFix(input logic [71:0] cw);
    logic [7:0]  s;
    logic [63:0] d;
    logic        par;
    int          k;
    d = cw[63:0];
    s = eccChk(d) ^ cw[71:64];
    par = ^cw;
    k = 0;
    for (int p = 3; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (par && s[6:0] == p[6:0])
          d[k] = ~d[k];
        k++;
      end
    end
    return {(s[6:0] != 7'h00) && !par, par, d};
  endfunction

  logic [ROW_W-1:0] mem [ROWS];
  logic [31:0]      ctrlQ;
  logic [15:0]      afLvlQ;
  logic [15:0]      aeLvlQ;
  logic [N_IRQ-1:0] irqStatQ;
  logic [N_IRQ-1:0] irqMaskQ;
  logic [15:0]      wpQ;
  logic [15:0]      rpQ;
  logic             fvQ;
  logic [1:0]       errQ;

  wire split  = ctrlQ[C_SPLIT];
  wire wide   = ctrlQ[C_WIDE];
  wire eccOn  = ctrlQ[C_ECC];
  wire fifoOn = ctrlQ[C_FIFO];
  wire fwft   = ctrlQ[C_FWFT];
  wire cascOn = ctrlQ[C_CASC];
  wire upper  = ctrlQ[C_UPPER];
  wire halfOn = split && !cascOn && !fifoOn;

  wire [2:0] capW = wide ? (split ? W36 : W72) : (split ? W18 : W36);
  wire [2:0] wc [NP];
  assign wc[0] = wide ? capW : clampW(ctrlQ[C_WA +: 3], capW, cascOn);
  assign wc[1] = fifoOn ? wc[0] : clampW(ctrlQ[C_WB +: 3], capW, cascOn);

  // Queue bookkeeping
  wire [15:0] cnt      = wpQ - rpQ;
  wire [15:0] depth    = 16'(17'h1 << (4'd15 - {1'b0, wc[0]}));
  wire        memFull  = cnt == depth;
  wire        memEmpty = cnt == 16'h0000;
  wire        push     = fifoOn && fifoWr && !memFull;
  wire        load     = fifoOn && !memEmpty && (fwft ? (!fvQ || fifoRd) : fifoRd);
  wire        ovfEv    = fifoOn && fifoWr && memFull;
  wire        unfEv    = fifoOn && fifoRd && (fwft ? !fvQ : memEmpty);
  wire [71:0] fMask    = (72'h1 << wBits(wc[0])) - 72'h1;
  wire [71:0] fRowDat  = mem[rowOf(wc[0], rpQ)];
  wire [71:0] fData    = (fRowDat >> bitOfs(wc[0], rpQ)) & fMask;

  // Per-port view
  logic             pEn   [NP];
  logic             pWe   [NP];
  logic             pHalf [NP];
  logic             pCasc [NP];
  logic [15:0]      ad    [NP];
  logic [71:0]      din   [NP];
  logic             inBlk [NP];
  logic             pWr   [NP];
  logic             upd   [NP];
  logic [8:0]       row   [NP];
  logic [71:0]      merged[NP];
  logic [71:0]      dout  [NP];
  logic             cOut  [NP];
  logic [1:0]       pErr  [NP];

  assign pEn[0]   = enA;
  assign pEn[1]   = enB;
  assign pWe[0]   = weA;
  assign pWe[1]   = weB;
  assign pHalf[0] = halfA;
  assign pHalf[1] = halfB;
  assign pCasc[0] = cascInA;
  assign pCasc[1] = cascInB;
  assign ad[0]    = fifoOn ? wpQ : addrA;
  assign ad[1]    = addrB;
  assign din[0]   = fifoOn ? fifoDin : dinA;
  assign din[1]   = dinB;

  assign pWr[0] = fifoOn ? push : (pEn[0] && pWe[0] && inBlk[0]);
  assign pWr[1] = !fifoOn && !wide && pEn[1] && pWe[1] && inBlk[1];
  assign upd[0] = !fifoOn && !wide && pEn[0] && inBlk[0];
  assign upd[1] = !fifoOn && pEn[1] && inBlk[1];

  for (genvar p = 0; p < NP; p++) begin : g_port
    logic [71:0] rdQ;
    logic [71:0] pipeQ;
    logic        hiQ;
    logic        hiPQ;
    logic [1:0]  eQ;
    wire [1:0]   wm     = ctrlQ[C_WM + 2 * p +: 2];
    wire         pipe   = ctrlQ[C_PIPE + p];
    wire [8:0]   rowRaw = rowOf(wc[p], ad[p]);
    wire [6:0]   ofs    = bitOfs(wc[p], ad[p]);
    wire [71:0]  wmask  = (72'h1 << wBits(wc[p])) - 72'h1;
    wire         eccW   = (p == 0) && eccOn && wide && wc[p] == W72;
    wire         eccR   = (p == 1) && eccOn && wide && wc[p] == W72;
    wire [71:0]  old    = mem[row[p]];
    wire [65:0]  fix    = eccFix(old);
    wire [71:0]  wdat   = eccW ? {eccChk(din[p][63:0]), din[p][63:0]} : din[p] << ofs;
    wire [71:0]  rdOld  = eccR ? {old[71:64], fix[63:0]} : (old >> ofs) & wmask;
    wire [71:0]  rdNew  = din[p] & wmask;
    wire         keep   = pWr[p] && wm == WM_NO_CHANGE;
    wire [71:0]  dSel   = pipe ? pipeQ : rdQ;
    wire         hiSel  = pipe ? hiPQ : hiQ;

    assign inBlk[p]  = !cascOn || ad[p][15] == upper;
    assign row[p]    = halfOn ? {pHalf[p], rowRaw[7:0]} : rowRaw;
    assign merged[p] = (old & ~(wmask << ofs)) | (wdat & (wmask << ofs));
    // Upper block of a cascade forwards the lower block's bit only until its first access, since hiQ loads only in-block addresses
    assign dout[p]   = (cascOn && upper && !hiSel) ? {71'h0, pCasc[p]} : dSel;
    assign cOut[p]   = dSel[0];
    assign pErr[p]   = eQ;

    always_ff @(posedge clk) begin
      if (reset) begin
        rdQ   <= 72'h0;
        pipeQ <= 72'h0;
        hiQ   <= 1'b0;
        hiPQ  <= 1'b0;
        eQ    <= 2'b00;
      end else begin
        pipeQ <= rdQ;
        hiPQ  <= hiQ;
        eQ    <= (upd[p] && eccR) ? fix[65:64] : 2'b00;
        if (upd[p]) begin
          hiQ <= ad[p][15];
          if (!keep)
            rdQ <= (pWr[p] && wm == WM_WRITE_FIRST) ? rdNew : rdOld;
        end
      end
    end
  end

  // Same-row writes from both ports in one cycle are undefined; port B wins
  always_ff @(posedge clk) begin
    if (pWr[0])
      mem[row[0]] <= merged[0];
    if (pWr[1])
      mem[row[1]] <= merged[1];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wpQ      <= 16'h0000;
      rpQ      <= 16'h0000;
      fvQ      <= 1'b0;
      fifoDout <= 72'h0;
    end else begin
      if (push)
        wpQ <= wpQ + 16'h0001;
      if (load) begin
        rpQ      <= rpQ + 16'h0001;
        fifoDout <= fData;
      end
      if (load)
        fvQ <= 1'b1;
      else if (fifoRd)
        fvQ <= 1'b0;
    end
  end

  assign fifoFull        = memFull;
  assign fifoEmpty       = fwft ? !fvQ : memEmpty;
  assign fifoAlmostFull  = cnt >= afLvlQ;
  assign fifoAlmostEmpty = cnt <= aeLvlQ;
  assign doutA           = dout[0];
  assign doutB           = dout[1];
  assign cascOutA        = cOut[0];
  assign cascOutB        = cOut[1];
  assign eccSingle       = pErr[1][0];
  assign eccDouble       = pErr[1][1];

  // Standalone codec for external memories, one cycle latency
  always_ff @(posedge clk) begin
    if (reset) begin
      extEncCheck  <= 8'h00;
      extDecOut    <= 64'h0;
      extDecSingle <= 1'b0;
      extDecDouble <= 1'b0;
    end else begin
      extEncCheck <= eccChk(extEncIn);
      {extDecDouble, extDecSingle, extDecOut} <= eccFix(extDecIn);
    end
  end

  // Register file
  wire wrCtrl = regWr && regAddr == OFS_CTRL;
  wire wrAf   = regWr && regAddr == OFS_AFULL;
  wire wrAe   = regWr && regAddr == OFS_AEMPTY;
  wire wrIrq  = regWr && regAddr == OFS_IRQ;
  wire wrMask = regWr && regAddr == OFS_MASK;

  wire [N_IRQ-1:0] irqEv;
  assign irqEv[I_OVF] = ovfEv;
  assign irqEv[I_UNF] = unfEv;
  assign irqEv[I_SBE] = pErr[1][0];
  assign irqEv[I_DBE] = pErr[1][1];
  // A new event in the clearing cycle survives the clear
  wire [N_IRQ-1:0] irqStatD = (irqStatQ & ~(wrIrq ? regWdata[N_IRQ-1:0] : 4'h0)) | irqEv;

  wire [31:0] statWord = {12'h000, fifoAlmostEmpty, fifoAlmostFull, fifoEmpty, fifoFull, cnt};
  wire [31:0] rdMux =
    (regAddr == OFS_CTRL)   ? ctrlQ :
    (regAddr == OFS_AFULL)  ? {16'h0000, afLvlQ} :
    (regAddr == OFS_AEMPTY) ? {16'h0000, aeLvlQ} :
    (regAddr == OFS_STAT)   ? statWord :
    (regAddr == OFS_IRQ)    ? {28'h0, irqStatQ} :
    (regAddr == OFS_MASK)   ? {28'h0, irqMaskQ} : 32'h0;

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrlQ    <= CTRL_RST;
      afLvlQ   <= AFULL_RST;
      aeLvlQ   <= AEMPTY_RST;
      irqStatQ <= 4'h0;
      irqMaskQ <= 4'h0;
      regRdata <= 32'h0;
    end else begin
      if (wrCtrl)
        ctrlQ <= regWdata;
      if (wrAf)
        afLvlQ <= regWdata[15:0];
      if (wrAe)
        aeLvlQ <= regWdata[15:0];
      if (wrMask)
        irqMaskQ <= regWdata[N_IRQ-1:0];
      irqStatQ <= irqStatD;
      regRdata <= regRd ? rdMux : 32'h0;
    end
  end

  assign irq = |(irqStatQ & irqMaskQ);
endmodule

// File: dpbr_pkg.sv
package dpbr_pkg;
  localparam int ROWS   = 512;
  localparam int ROW_W  = 72;
  localparam int ADDR_W = 16;
  localparam int REG_AW = 5;
  localparam int N_IRQ  = 4;

  localparam logic [REG_AW-1:0] OFS_CTRL   = 5'h00;
  localparam logic [REG_AW-1:0] OFS_AFULL  = 5'h04;
  localparam logic [REG_AW-1:0] OFS_AEMPTY = 5'h08;
  localparam logic [REG_AW-1:0] OFS_STAT   = 5'h0c;
  localparam logic [REG_AW-1:0] OFS_IRQ    = 5'h10;
  localparam logic [REG_AW-1:0] OFS_MASK   = 5'h14;

  // Control register fields
  localparam int C_SPLIT = 0;
  localparam int C_WIDE  = 1;
  localparam int C_ECC   = 2;
  localparam int C_FIFO  = 3;
  localparam int C_FWFT  = 4;
  localparam int C_CASC  = 5;
  localparam int C_UPPER = 6;
  localparam int C_WA    = 8;
  localparam int C_WB    = 12;
  localparam int C_PIPE  = 16;
  localparam int C_WM    = 18;

  // Status register fields
  localparam int S_FULL  = 16;
  localparam int S_EMPTY = 17;
  localparam int S_AF    = 18;
  localparam int S_AE    = 19;

  // Interrupt bits
  localparam int I_OVF = 0;
  localparam int I_UNF = 1;
  localparam int I_SBE = 2;
  localparam int I_DBE = 3;

  localparam logic [31:0] CTRL_RST   = 32'h0000_5500;
  localparam logic [15:0] AFULL_RST  = 16'h0300;
  localparam logic [15:0] AEMPTY_RST = 16'h0010;

  typedef enum logic [2:0] {
    W1 = 3'h0, W2 = 3'h1, W4 = 3'h2, W9 = 3'h3, W18 = 3'h4, W36 = 3'h5, W72 = 3'h6
  } dpbr_width_t;

  typedef enum logic [1:0] {
    WM_READ_FIRST = 2'h0, WM_WRITE_FIRST = 2'h1, WM_NO_CHANGE = 2'h2
  } dpbr_wmode_t;
endpackage

// File: dpbr_properties.sv
module dpbr_properties
  import dpbr_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              regRd,
  input wire logic [31:0]       regRdata,
  input wire logic              enA,
  input wire logic              enB,
  input wire logic [ROW_W-1:0]  doutA,
  input wire logic [ROW_W-1:0]  doutB,
  input wire logic              fifoWr,
  input wire logic              fifoRd,
  input wire logic              fifoFull,
  input wire logic              fifoEmpty,
  input wire logic              fifoAlmostFull,
  input wire logic              fifoAlmostEmpty,
  input wire logic [63:0]       extEncIn,
  input wire logic [7:0]        extEncCheck,
  input wire logic [ROW_W-1:0]  extDecIn,
  input wire logic [63:0]       extDecOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence emptyRead;
    fifoEmpty && fifoRd && !fifoWr;
  endsequence
  sequence fullWrite;
    fifoFull && fifoWr && !fifoRd;
  endsequence

  rdata_idle_a: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data not idle");
  // Two idle edges, so a pipelined answer may still land after the first
  hold_a_out_a: assert property (!enA && !$past(enA) |=> $stable(doutA))
    else $error("port a output moved while idle");
  hold_b_out_a: assert property (!enB && !$past(enB) |=> $stable(doutB))
    else $error("port b output moved without access");
  empty_read_a: assert property (emptyRead |=> fifoEmpty)
    else $error("read while empty changed state");
  full_write_a: assert property (fullWrite |=> fifoFull)
    else $error("write while full changed state");
  flags_excl_a: assert property (!(fifoFull && fifoEmpty))
    else $error("full and empty together");
  full_af_a: assert property (fifoFull |-> fifoAlmostFull)
    else $error("full without almost full");
  empty_ae_a: assert property (fifoEmpty |-> fifoAlmostEmpty)
    else $error("empty without almost empty");
  enc_hold_a: assert property (!$past(reset) && $stable(extEncIn) |=> $stable(extEncCheck))
    else $error("encoder output moved");
  dec_hold_a: assert property (!$past(reset) && $stable(extDecIn) |=> $stable(extDecOut))
    else $error("decoder output moved");
endmodule

// File: dpbr_user.sv
module dpbr_user (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        run,
  input  wire logic        fifoFull,
  output logic             fifoWr,
  output logic [71:0]      fifoDin
);
  logic [35:0] seq_q;
  // Keeps pushing while full so refused writes are exercised
  assign fifoWr  = run;
  assign fifoDin = {36'h0, seq_q};
  // Advance only on accepted words so the stored sequence has no gaps
  always_ff @(posedge clk) begin
    if (reset) seq_q <= 36'h0;
    else if (run && !fifoFull) seq_q <= seq_q + 36'h1;
  end
endmodule

// File: dual_port_block_ram_fifo_ecc_tb.sv
module dual_port_block_ram_fifo_ecc_tb
  import dpbr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [REG_AW-1:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic regWr, regRd, irq, run, fifoWr, fifoRd;
  logic enA, weA, halfA, enB, weB, halfB, cascInA, cascInB, cascOutA, cascOutB;
  logic [ADDR_W-1:0] addrA, addrB;
  logic [ROW_W-1:0] dinA, doutA, dinB, doutB, fifoDin, fifoDout, extDecIn;
  logic fifoFull, fifoEmpty, fifoAlmostFull, fifoAlmostEmpty, eccSingle, eccDouble;
  logic [63:0] extEncIn, extDecOut;
  logic [7:0] extEncCheck, c;
  logic extDecSingle, extDecDouble;
  logic [35:0] old, nw;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;

  dpbr_top DUT (.*);
  dpbr_user u_user (.*);

  always #2 clk = ~clk;

  task automatic chk(string n, logic [71:0] e, logic [71:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wreg(logic [4:0] a, logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rreg(string n, logic [4:0] a, logic [31:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(n, e, regRdata);
  endtask

  task automatic acc(bit b, logic w, logic [15:0] a, logic [71:0] d);
    @(posedge clk);
    if (b) begin
      {enB, weB, addrB, dinB} <= {1'b1, w, a, d};
    end else begin
      {enA, weA, addrA, dinA} <= {1'b1, w, a, d};
    end
    @(posedge clk);
    {enA, enB} <= 2'h0;
    #1;
  endtask

  task automatic pop;
    @(posedge clk);
    fifoRd <= 1'b1;
    @(posedge clk);
    fifoRd <= 1'b0;
    #1;
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Whole run needs roughly 3200 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    {regWr, regRd, enA, weA, halfA, enB, weB, halfB, cascInA, cascInB, run, fifoRd} = '0;
    {regAddr, regWdata, addrA, addrB, dinA, dinB, extEncIn, extDecIn} = '0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rreg("ctrl", OFS_CTRL, CTRL_RST);
    rreg("afull", OFS_AFULL, 32'(AFULL_RST));
    rreg("aempty", OFS_AEMPTY, 32'(AEMPTY_RST));
    rreg("status", OFS_STAT, 32'h000a_0000);
    rreg("unmapped", 5'h1c, 32'h0);
    $display("test reset done");
    for (int m = 0; m < 3; m++) begin
      old = 36'h1_0000_0000 + 36'(m);
      nw = 36'h5_5555_0000 + 36'(m);
      wreg(OFS_CTRL, CTRL_RST | (32'(m) << C_WM));
      acc(0, 1, 16'h5, old);
      acc(0, 1, 16'h6, 36'haa);
      acc(0, 0, 16'h6, 36'h0);
      acc(0, 1, 16'h5, nw);
      chk("wmode", m == 0 ? old : m == 1 ? nw : 36'haa, doutA[35:0]);
      acc(1, 0, 16'h5, 36'h0);
      chk("shared", nw, doutB[35:0]);
    end
    wreg(OFS_CTRL, CTRL_RST | (32'h1 << C_PIPE));
    acc(0, 0, 16'h5, 36'h0);
    chk("pipe early", 1'b0, doutA[35:0] === nw);
    @(posedge clk);
    #1 chk("pipe late", nw, doutA[35:0]);
    wreg(OFS_CTRL, 32'h0000_5000);
    for (int i = 0; i < 8; i++) acc(0, 1, 16'(i), 36'((8'h8d >> i) & 8'h1));
    acc(1, 0, 16'h0, 36'h0);
    chk("width map", 8'h8d, doutB[7:0]);
    chk("casc out", 1'b1, cascOutB);
    $display("test ram done");
    extEncIn <= 64'h0123_4567_89ab_cdef;
    repeat (2) @(posedge clk);
    #1 c = extEncCheck;
    for (int k = 0; k < 3; k++) begin
      extDecIn <= {c, extEncIn ^ ((64'h1 << k) - 64'h1)};
      repeat (2) @(posedge clk);
      #1 chk("dec single", k == 1, extDecSingle);
      chk("dec double", k == 2, extDecDouble);
      if (k < 2) chk("dec data", extEncIn, extDecOut);
    end
    // Store a codeword with one flipped bit while the codec is off, then read it back protected
    wreg(OFS_CTRL, 32'h0000_6002);
    acc(0, 1, 16'h0, {c, extEncIn ^ 64'h1});
    wreg(OFS_CTRL, 32'h0000_6006);
    acc(1, 0, 16'h0, 72'h0);
    chk("ecc data", extEncIn, doutB[63:0]);
    chk("ecc single", 1'b1, eccSingle);
    chk("ecc double", 1'b0, eccDouble);
    rreg("irq single", OFS_IRQ, 32'h4);
    wreg(OFS_IRQ, 32'h4);
    $display("test ecc done");
    wreg(OFS_CTRL, CTRL_RST | 32'h8);
    wreg(OFS_AFULL, 32'h4);
    wreg(OFS_AEMPTY, 32'h2);
    wreg(OFS_MASK, 32'h0);
    @(posedge clk) run <= 1'b1;
    for (int i = 0; i < 2000 && fifoFull !== 1'b1; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    run <= 1'b0;
    rreg("status full", OFS_STAT, 32'h0005_0400);
    rreg("irq overflow", OFS_IRQ, 32'h1);
    for (int i = 0; i < 1024; i++) begin
      pop();
      chk("fifo data", 36'(i), fifoDout[35:0]);
      chk("almost empty", 1023 - i <= 2, fifoAlmostEmpty);
      chk("almost full", 1023 - i >= 4, fifoAlmostFull);
    end
    pop();
    chk("empty", 1'b1, fifoEmpty);
    rreg("irq underflow", OFS_IRQ, 32'h3);
    chk("irq masked", 1'b0, irq);
    wreg(OFS_MASK, 32'h1);
    #1 chk("irq on", 1'b1, irq);
    wreg(OFS_IRQ, 32'h1);
    #1 chk("irq cleared", 1'b0, irq);
    $display("test fifo done");
    wreg(OFS_CTRL, CTRL_RST | 32'h18);
    @(posedge clk) run <= 1'b1;
    @(posedge clk) run <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("lookahead word", 36'd1024, fifoDout[35:0]);
    chk("lookahead empty", 1'b0, fifoEmpty);
    pop();
    chk("lookahead drained", 1'b1, fifoEmpty);
    $display("test lookahead done");
    give_verdict();
  end
endmodule

bind dpbr_top dpbr_properties u_props (.*);
